//--- core/bcvc_pkg.sv
// package: register map, field layout, reset values and voltage decode constants
package bcvc_pkg;
  // register addresses of the second buck channel
  localparam logic [7:0] BCVC_ADDR_STANDBY = 8'h20;  // buck2_standby_voltage
  localparam logic [7:0] BCVC_ADDR_RSVD    = 8'h21;  // buck2_reserved
  localparam logic [7:0] BCVC_ADDR_CTRL    = 8'h22;  // buck2_control_status
  localparam logic [7:0] BCVC_ADDR_ACTIVE  = 8'h23;  // buck2_active_voltage
  // field positions
  localparam int BCVC_CODE_MSB  = 5;                 // voltage code [5:0]
  localparam int BCVC_BIT_EN    = 0;                 // enable in control reg
  localparam int BCVC_BIT_PGOOD = 1;                 // power-good in control reg
  localparam int BCVC_BIT_UNMSK = 2;                 // fault_report_unmask
  localparam int BCVC_BIT_SPAN  = 6;                 // voltage_span_select
  // reset values (none documented, plain defaults)
  localparam logic [5:0] BCVC_RST_CODE  = 6'h00;
  localparam logic       BCVC_RST_EN    = 1'b0;
  localparam logic       BCVC_RST_UNMSK = 1'b0;
  localparam logic       BCVC_RST_SPAN  = 1'b0;
  localparam logic [7:0] BCVC_RD_ZERO   = 8'h00;     // read-only bits read zero
  // decode: millivolt results
  localparam logic [12:0] BCVC_MV_LO_FLOOR = 13'h0320;  // low range codes 1..7, 800 mV
  localparam logic [12:0] BCVC_MV_LO_BASE  = 13'h0271;  // low: 625 + 25*code
  localparam logic [12:0] BCVC_MV_LO_STEP  = 13'h0019;  // 25 mV
  localparam logic [12:0] BCVC_MV_HI_BASE  = 13'h04e2;  // high: 1250 + 50*code
  localparam logic [12:0] BCVC_MV_HI_STEP  = 13'h0032;  // 50 mV
  localparam logic [5:0]  BCVC_CODE_ADJ    = 6'h00;     // external adjust code
  localparam logic [5:0]  BCVC_CODE_LO_MIN = 6'h08;     // first stepped low code
  localparam logic [5:0]  BCVC_CODE_ODD    = 6'h22;     // literal low entry
  localparam logic [12:0] BCVC_MV_ODD      = 13'h05c8;  // 1480 mV
  // power-good input synchroniser depth
  localparam int BCVC_SYNC_STAGES = 2;
endpackage : bcvc_pkg

//--- core/bcvc_sync.sv
// module: two flip-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
module bcvc_sync (
  input  wire logic clk,     // system clock
  input  wire logic rst_n,   // synchronous reset, active low
  input  wire logic d_in,    // asynchronous level
  output logic      q_out    // synchronised level
);
  import bcvc_pkg::*;
  logic [BCVC_SYNC_STAGES-1:0] sr_r;    // shift chain
  logic [BCVC_SYNC_STAGES-1:0] sr_nxt;  // next chain

  // first stage feeds only the second
  always_comb begin
    sr_nxt = {sr_r[BCVC_SYNC_STAGES-2:0], d_in};
  end

  // registers only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sr_r <= '0;
    end else begin
      sr_r <= sr_nxt;
    end
  end

  assign q_out = sr_r[BCVC_SYNC_STAGES-1];
endmodule : bcvc_sync

//--- core/bcvc_decode.sv
// module: six-bit voltage code to millivolt decode for both ranges
`timescale 1ns/100ps
module bcvc_decode (
  input  wire logic        span,      // voltage_span_select
  input  wire logic [5:0]  code,      // voltage code
  output logic             adjust,    // external adjustable output selected
  output logic [12:0]      mv         // target in millivolts, 0 when adjust
);
  import bcvc_pkg::*;
  logic [12:0] code_w;  // code widened for arithmetic

  // table decode; arithmetic where steps are regular, literal where not
  always_comb begin
    code_w = {7'h00, code};
    adjust = 1'b0;
    mv     = '0;
    if (code == BCVC_CODE_ADJ) begin
      adjust = 1'b1;
    end else if (span) begin
      mv = BCVC_MV_HI_BASE + BCVC_MV_HI_STEP * code_w;
    end else if (code < BCVC_CODE_LO_MIN) begin
      mv = BCVC_MV_LO_FLOOR;
    end else if (code == BCVC_CODE_ODD) begin
      mv = BCVC_MV_ODD;
    end else begin
      mv = BCVC_MV_LO_BASE + BCVC_MV_LO_STEP * code_w;
    end
  end
endmodule : bcvc_decode

//--- core/bcvc_top.sv
// module: second buck channel register set and regulator setpoint control
`timescale 1ns/100ps
// Function
// - standby register bits 5:0 hold standby code
// - active register bits 5:0 hold active code
// - control register bit 0 enables converter
// - control register bit 1 reads power-good
// - control register bit 2 unmasks fault report
// - active register bit 6 selects voltage range
// - unused bits are read-only, read zero
// - code zero selects external adjustable output
// - low range 0.800 floor, 25 mV steps
// - low code 100010 decodes to 1.480 V
// - high range 1.300 to 4.400, 50 mV
module bcvc_top (
  input  wire logic        clk,           // 100 MHz system clock
  input  wire logic        rst_n,         // synchronous reset, active low
  input  wire logic        reg_wr,        // register write strobe from serial port
  input  wire logic        reg_rd,        // register read strobe from serial port
  input  wire logic [7:0]  reg_addr,      // register address
  input  wire logic [7:0]  reg_wdata,     // write data
  output logic [7:0]       reg_rdata,     // read data, valid cycle after reg_rd
  output logic             reg_hit,       // address decoded this access
  input  wire logic        pgood_in,      // converter in-regulation, asynchronous
  input  wire logic        standby_in,    // standby indication, asynchronous
  input  wire logic        fault_in,      // raw output-voltage fault, asynchronous
  output logic             conv_en,       // converter enable
  output logic             fault_out,     // fault report after mask
  output logic             span_out,      // range presented to regulator
  output logic [5:0]       code_out,      // selected code to regulator
  output logic             adjust_out,    // external adjust mode
  output logic [12:0]      mv_out         // target millivolts
);
  import bcvc_pkg::*;

  // register state
  logic [5:0]  stby_code_r, stby_code_nxt;   // standby_voltage_code
  logic [5:0]  act_code_r,  act_code_nxt;    // active_voltage_code
  logic        en_r,        en_nxt;          // converter enable
  logic        unmask_r,    unmask_nxt;      // fault_report_unmask
  logic        span_r,      span_nxt;        // voltage_span_select
  logic [7:0]  rdata_r,     rdata_nxt;       // read data
  logic        hit_r,       hit_nxt;         // decode indication
  // outputs toward the regulator
  logic        fault_r,     fault_nxt;
  logic [5:0]  code_r,      code_nxt;
  logic        spano_r,     spano_nxt;
  logic        adj_r,       adj_nxt;
  logic [12:0] mv_r,        mv_nxt;
  // synchronised pins
  logic        pgood_s;                      // power-good after two flops
  logic        stby_s;                       // standby after two flops
  logic        fault_s;                      // fault after two flops
  // decode results
  logic        dec_adj;
  logic [12:0] dec_mv;
  logic        addr_ok;                      // address maps to this channel

  // every asynchronous pin crosses two flip-flops before logic looks at it
  bcvc_sync u_sync_pg (.clk(clk), .rst_n(rst_n), .d_in(pgood_in),   .q_out(pgood_s));
  bcvc_sync u_sync_sb (.clk(clk), .rst_n(rst_n), .d_in(standby_in), .q_out(stby_s));
  bcvc_sync u_sync_ft (.clk(clk), .rst_n(rst_n), .d_in(fault_in),   .q_out(fault_s));

  // address decode over the four channel registers
  always_comb begin
    addr_ok = (reg_addr == BCVC_ADDR_STANDBY) || (reg_addr == BCVC_ADDR_RSVD) ||
              (reg_addr == BCVC_ADDR_CTRL)    || (reg_addr == BCVC_ADDR_ACTIVE);
  end

  // register writes; read-only bits ignore write data
  always_comb begin
    stby_code_nxt = stby_code_r;
    act_code_nxt  = act_code_r;
    en_nxt        = en_r;
    unmask_nxt    = unmask_r;
    span_nxt      = span_r;
    if (reg_wr) begin
      unique case (reg_addr)
        BCVC_ADDR_STANDBY: begin
          stby_code_nxt = reg_wdata[BCVC_CODE_MSB:0];
        end
        BCVC_ADDR_CTRL: begin
          en_nxt     = reg_wdata[BCVC_BIT_EN];
          unmask_nxt = reg_wdata[BCVC_BIT_UNMSK];
        end
        BCVC_ADDR_ACTIVE: begin
          act_code_nxt = reg_wdata[BCVC_CODE_MSB:0];
          // no guard here: software must keep the code valid across a span change
          span_nxt     = reg_wdata[BCVC_BIT_SPAN];
        end
        default: begin
          // reserved or unmapped: write has no effect
        end
      endcase
    end
  end

  // read path; reserved bits read zero, status is live
  always_comb begin
    rdata_nxt = rdata_r;
    hit_nxt   = 1'b0;
    if (reg_rd) begin
      hit_nxt   = addr_ok;
      rdata_nxt = BCVC_RD_ZERO;
      unique case (reg_addr)
        BCVC_ADDR_STANDBY: begin
          rdata_nxt[BCVC_CODE_MSB:0] = stby_code_r;
        end
        BCVC_ADDR_CTRL: begin
          rdata_nxt[BCVC_BIT_EN]    = en_r;
          rdata_nxt[BCVC_BIT_PGOOD] = pgood_s;
          rdata_nxt[BCVC_BIT_UNMSK] = unmask_r;
        end
        BCVC_ADDR_ACTIVE: begin
          rdata_nxt[BCVC_CODE_MSB:0] = act_code_r;
          rdata_nxt[BCVC_BIT_SPAN]   = span_r;
        end
        default: begin
          // reserved register and unmapped addresses read zero
        end
      endcase
    end else if (reg_wr) begin
      hit_nxt = addr_ok;
    end
  end

  // shared decode of the selected code; it reads code_nxt so that mv_out and
  // adjust_out change in the same cycle as code_out, never one cycle behind
  bcvc_decode u_dec (
    .span   (span_r),
    .code   (code_nxt),
    .adjust (dec_adj),
    .mv     (dec_mv)
  );

  // setpoint selection: standby code while standby is asserted
  always_comb begin
    code_nxt  = stby_s ? stby_code_r : act_code_r;
    spano_nxt = span_r;
    adj_nxt   = dec_adj;
    mv_nxt    = dec_mv;
    fault_nxt = fault_s & unmask_r;
  end

  // register all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stby_code_r <= BCVC_RST_CODE;
      act_code_r  <= BCVC_RST_CODE;
      en_r        <= BCVC_RST_EN;
      unmask_r    <= BCVC_RST_UNMSK;
      span_r      <= BCVC_RST_SPAN;
      rdata_r     <= BCVC_RD_ZERO;
      hit_r       <= 1'b0;
      fault_r     <= 1'b0;
      code_r      <= BCVC_RST_CODE;
      spano_r     <= BCVC_RST_SPAN;
      adj_r       <= 1'b0;
      mv_r        <= '0;
    end else begin
      stby_code_r <= stby_code_nxt;
      act_code_r  <= act_code_nxt;
      en_r        <= en_nxt;
      unmask_r    <= unmask_nxt;
      span_r      <= span_nxt;
      rdata_r     <= rdata_nxt;
      hit_r       <= hit_nxt;
      fault_r     <= fault_nxt;
      code_r      <= code_nxt;
      spano_r     <= spano_nxt;
      adj_r       <= adj_nxt;
      mv_r        <= mv_nxt;
    end
  end

  // outputs come straight from flops
  assign reg_rdata  = rdata_r;
  assign reg_hit    = hit_r;
  assign conv_en    = en_r;
  assign fault_out  = fault_r;
  assign span_out   = spano_r;
  assign code_out   = code_r;
  assign adjust_out = adj_r;
  assign mv_out     = mv_r;

  // checks: one clock domain, so one default clocking and one reset disable serve them all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // write path: fields take the strobe's data one cycle after the write edge
  // standby code keeps only its six code bits
  chk_standby_write: assert property (
    reg_wr && reg_addr == BCVC_ADDR_STANDBY |=> stby_code_r == $past(reg_wdata[5:0]))
    else $error("standby code not stored");
  // active code and range share one byte and land together
  chk_active_write: assert property (
    reg_wr && reg_addr == BCVC_ADDR_ACTIVE |=> act_code_r == $past(reg_wdata[5:0]) &&
      span_r == $past(reg_wdata[6]))
    else $error("active code or span not stored");
  // enable reaches the converter pin straight from its field
  chk_enable_follow: assert property (
    reg_wr && reg_addr == BCVC_ADDR_CTRL |=> conv_en == $past(reg_wdata[0]))
    else $error("enable not following write");
  // a write to the reserved register must leave every field alone
  chk_reserved_write: assert property (
    reg_wr && reg_addr == BCVC_ADDR_RSVD |=> $stable(stby_code_r) && $stable(act_code_r) &&
      $stable(en_r) && $stable(unmask_r) && $stable(span_r))
    else $error("reserved write changed a field");

  // read path: data shows the fields as they stood at the read edge
  // standby register: code in the low six bits, zero above
  chk_standby_read: assert property (
    reg_rd && reg_addr == BCVC_ADDR_STANDBY |=> reg_rdata == {2'b00, $past(stby_code_r)})
    else $error("standby read wrong");
  // active register: range above the code, top bit zero
  chk_active_read: assert property (
    reg_rd && reg_addr == BCVC_ADDR_ACTIVE |=> reg_rdata == {1'b0, $past(span_r), $past(act_code_r)})
    else $error("active read wrong");
  // control register: enable and unmask read back what was written
  chk_ctrl_read: assert property (
    reg_rd && reg_addr == BCVC_ADDR_CTRL |=> reg_rdata[0] == $past(en_r) && reg_rdata[2] == $past(unmask_r))
    else $error("control read wrong");
  // power-good is live status, never a stored copy of write data
  chk_pgood_read: assert property (
    reg_rd && reg_addr == BCVC_ADDR_CTRL |=> reg_rdata[1] == $past(pgood_s))
    else $error("power-good read wrong");
  // read-only bits of every register read zero; the reserved register reads zero whole
  chk_reserved_zero: assert property (
    reg_rd |=> reg_rdata[7] == 1'b0 &&
      ($past(reg_addr) == BCVC_ADDR_ACTIVE || reg_rdata[6] == 1'b0) &&
      ($past(reg_addr) != BCVC_ADDR_CTRL || reg_rdata[7:3] == 5'h00) &&
      ($past(reg_addr) != BCVC_ADDR_RSVD || reg_rdata == 8'h00))
    else $error("reserved bits not zero");

  // regulator side: fault report gated by the unmask bit
  // masked: nothing gets through, whatever the raw fault does
  chk_fault_mask: assert property (
    !unmask_r |=> !fault_out)
    else $error("masked fault reported");
  // unmasked: a synchronised fault shows on the next cycle
  chk_fault_pass: assert property (
    unmask_r && fault_s |=> fault_out)
    else $error("unmasked fault not reported");
  // range reaches the regulator one cycle after its field
  chk_span_follow: assert property (
    reg_wr && reg_addr == BCVC_ADDR_ACTIVE |=> ##1 span_out == $past(reg_wdata[6], 2))
    else $error("span not presented");

  // decode corners, each held against a fixed table entry rather than the formula
  // code zero hands the output to the external divider
  chk_adjust_zero: assert property (
    code_nxt == BCVC_CODE_ADJ |=> adjust_out && mv_out == 13'h0000)
    else $error("code zero not adjustable");
  // any other code is a programmed voltage
  chk_adjust_off: assert property (
    code_nxt != BCVC_CODE_ADJ |=> !adjust_out)
    else $error("adjust set for programmed code");
  // low range codes below the first step all sit at the floor
  chk_low_floor: assert property (
    code_nxt inside {[6'h01:6'h07]} && !span_r |=> mv_out == 13'h0320)
    else $error("low floor wrong");
  // first stepped low code
  chk_low_step: assert property (
    code_nxt == 6'h08 && !span_r |=> mv_out == 13'h0339)
    else $error("low first step wrong");
  // top of the low range
  chk_low_top: assert property (
    code_nxt == 6'h3f && !span_r |=> mv_out == 13'h0898)
    else $error("low range top wrong");
  // the one low entry that leaves the grid
  chk_odd_entry: assert property (
    code_nxt == BCVC_CODE_ODD && !span_r |=> mv_out == BCVC_MV_ODD)
    else $error("literal entry wrong");
  // bottom of the high range
  chk_high_base: assert property (
    code_nxt == 6'h01 && span_r |=> mv_out == 13'h0514)
    else $error("high range base wrong");
  // first code of the second high group
  chk_high_group: assert property (
    code_nxt == 6'h10 && span_r |=> mv_out == 13'h0802)
    else $error("high second group wrong");
  // top of the high range
  chk_high_top: assert property (
    code_nxt == 6'h3f && span_r |=> mv_out == 13'h1130)
    else $error("high range top wrong");

  // code selection toward the regulator
  // standby code while the synchronised standby level is high
  chk_standby_sel: assert property (
    stby_s |=> code_out == $past(stby_code_r))
    else $error("standby code not selected");
  // active code otherwise
  chk_active_sel: assert property (
    !stby_s |=> code_out == $past(act_code_r))
    else $error("active code not selected");

  // main scenarios: standby exit, high range write, fault report, odd entry, status read
  cov_standby: cover property (stby_s ##1 !stby_s);
  cov_span_hi: cover property (reg_wr && reg_addr == BCVC_ADDR_ACTIVE && reg_wdata[6]);
  cov_fault: cover property (fault_out);
  cov_odd: cover property (mv_out == BCVC_MV_ODD);
  cov_pgood_read: cover property (reg_rd && reg_addr == BCVC_ADDR_CTRL && pgood_s);
endmodule : bcvc_top

//--- verif/bcvc_host.sv
// host model: register strobes as the serial front end issues them
`timescale 1ns/100ps
module bcvc_host (
  input  wire logic       clk,        // system clock
  input  wire logic [7:0] reg_rdata,  // read data from the register set
  input  wire logic       reg_hit,    // decoded access pulse
  output logic            reg_wr,     // write strobe
  output logic            reg_rd,     // read strobe
  output logic [7:0]      reg_addr,   // register address
  output logic [7:0]      reg_wdata   // write data
);
  import bcvc_pkg::*;
  // idle levels at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write, driven off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;   // released lines must not keep the last value
    reg_wdata = ~d;
  endtask : wr
  // one-cycle read; answer stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
    h        = reg_hit;
  endtask : rd
  // span and code go in one byte, so no mixed-range setpoint ever appears
  task automatic set_point(input logic span, input logic [5:0] code);
    wr(BCVC_ADDR_ACTIVE, {1'b0, span, code});
  endtask : set_point
endmodule : bcvc_host

//--- verif/testbench.sv
// testbench: register access, decode table and regulator output checks
`timescale 1ns/100ps
module testbench;
  import bcvc_pkg::*;
  logic        clk, rst_n;            // clock and reset
  logic        wr, rd, hit;           // register strobes and hit pulse
  logic [7:0]  addr, wdata, rdata;    // register bus
  logic        pgood, standby, fault; // converter side inputs
  logic        conv_en, fault_out, span_out, adjust;
  logic [5:0]  code;                  // selected code
  logic [12:0] mv;                    // target millivolts
  logic [7:0]  rv;                    // last read data
  logic        rh;                    // last read hit
  int          miscompares, cmp_count, cyc;
  // decode cases: bit 6 is the range, bits 5:0 the code
  logic [6:0]  cases [12] = '{7'h00, 7'h01, 7'h07, 7'h08, 7'h21, 7'h22,
                              7'h3f, 7'h40, 7'h41, 7'h4f, 7'h50, 7'h7f};
  // expected millivolts for each case, read off the code table
  logic [12:0] exp_mvs [12] = '{13'h0000, 13'h0320, 13'h0320, 13'h0339, 13'h05aa, 13'h05c8,
                                13'h0898, 13'h0000, 13'h0514, 13'h07d0, 13'h0802, 13'h1130};
  bcvc_top u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .pgood_in(pgood), .standby_in(standby),
    .fault_in(fault), .conv_en(conv_en), .fault_out(fault_out), .span_out(span_out),
    .code_out(code), .adjust_out(adjust), .mv_out(mv));
  bcvc_host u_host (.clk(clk), .reg_rdata(rdata), .reg_hit(hit), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // register read results
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg
  // regulator side pin values
  task automatic cmp_pin(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_pin
  // read one register and check data and hit together
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic eh);
    u_host.rd(a, rv, rh);
    cmp_reg(rv, e);
    cmp_pin({12'h000, rh}, {12'h000, eh});
  endtask : chk_rd
  // covers field update, output register and the two-flop input chains
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle
  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end
  // main sequence
  initial begin
    cyc = 0;
    miscompares = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    pgood = 1'b0;
    standby = 1'b0;
    fault = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 32; a < 36; a++) begin
      chk_rd(a[7:0], 8'h00, 1'b1);
    end
    u_host.wr(BCVC_ADDR_STANDBY, 8'hff);
    chk_rd(BCVC_ADDR_STANDBY, 8'h3f, 1'b1);
    u_host.wr(BCVC_ADDR_RSVD, 8'hff);
    chk_rd(BCVC_ADDR_RSVD, 8'h00, 1'b1);
    u_host.wr(BCVC_ADDR_CTRL, 8'hff);
    chk_rd(BCVC_ADDR_CTRL, 8'h05, 1'b1);
    u_host.wr(BCVC_ADDR_ACTIVE, 8'hff);
    chk_rd(BCVC_ADDR_ACTIVE, 8'h7f, 1'b1);
    chk_rd(8'h24, 8'h00, 1'b0);
    fault = 1'b1;
    pgood = 1'b1;
    settle();
    cmp_pin({12'h000, conv_en}, 13'h0001);
    cmp_pin({12'h000, fault_out}, 13'h0001);
    chk_rd(BCVC_ADDR_CTRL, 8'h07, 1'b1);
    // power-good is read-only: writing it must not stick
    u_host.wr(BCVC_ADDR_CTRL, 8'h02);
    settle();
    cmp_pin({12'h000, conv_en}, 13'h0000);
    cmp_pin({12'h000, fault_out}, 13'h0000);
    chk_rd(BCVC_ADDR_CTRL, 8'h02, 1'b1);
    pgood = 1'b0;
    settle();
    chk_rd(BCVC_ADDR_CTRL, 8'h00, 1'b1);
    // decode corners of both ranges
    foreach (cases[i]) begin
      u_host.set_point(cases[i][6], cases[i][5:0]);
      settle();
      cmp_pin(mv, exp_mvs[i]);
      cmp_pin({12'h000, adjust}, {12'h000, cases[i][5:0] == 6'h00});
      cmp_pin({12'h000, span_out}, {12'h000, cases[i][6]});
      cmp_pin({7'h00, code}, {7'h00, cases[i][5:0]});
    end
    // standby swaps the presented code and back
    u_host.wr(BCVC_ADDR_STANDBY, 8'h10);
    u_host.set_point(1'b0, 6'h08);
    standby = 1'b1;
    settle();
    cmp_pin({7'h00, code}, 13'h0010);
    cmp_pin(mv, 13'h0401);
    standby = 1'b0;
    settle();
    cmp_pin({7'h00, code}, 13'h0008);
    test_done();
  end
endmodule : testbench
